//--- logic/grs_pkg.sv
package grs_pkg;
   localparam int CLK_PERIOD_NS = 40;
   // Silence on the vertical reference for this long drops the lock flag.
   localparam int REF_LOSS_US = 50000;
   localparam int REF_LOSS_CYC = (REF_LOSS_US * 1000) / CLK_PERIOD_NS;
   localparam int NUM_REF_STDS = 36;
   localparam int NUM_OUT_STDS = 10;
   localparam int SEL_W = 6;
   localparam int LOW_SEL_W = 4;
   localparam int RATE_W = 2;
   localparam int TSET_W = 4;
   localparam int NUM_TSETS = 9;
   localparam int SYNC_STAGES = 3;
   localparam int DUR_CNT_W = 21;
   localparam logic [SEL_W-1:0] FMT_RST = 6'h00;
   localparam logic [TSET_W-1:0] TSET_RST = 4'h0;

   typedef enum logic [RATE_W-1:0] {
      RATE_14M32 = 2'h0,
      RATE_27M = 2'h1,
      RATE_36M = 2'h2,
      RATE_54M = 2'h3
   } grs_rate_t;

   typedef enum logic [2:0] {
      ST_NOREF = 3'h1,
      ST_SEEK = 3'h2,
      ST_LOCKED = 3'h4
   } grs_state_t;

   // Sample clock rate for each format code; codes 0 and 11..15 unused.
   localparam grs_rate_t RATE_TAB [0:15] = '{
      RATE_27M, RATE_27M, RATE_27M, RATE_36M, RATE_36M, RATE_54M,
      RATE_54M, RATE_14M32, RATE_14M32, RATE_27M, RATE_54M,
      RATE_27M, RATE_27M, RATE_27M, RATE_27M, RATE_27M
   };
   // Timing set for each format code.
   localparam logic [TSET_W-1:0] TSET_TAB [0:15] = '{
      4'h0, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h8,
      4'h0, 4'h0, 4'h0, 4'h0, 4'h0
   };
endpackage

//--- logic/grs_ref_edge.sv
`timescale 1ns/10ps
module grs_ref_edge
   import grs_pkg::*;
#(
   parameter int CNT_W = grs_pkg::DUR_CNT_W
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic genlockEn,
   input wire logic refIn,
   output logic leadPulse,
   output logic activeHigh,
   output logic polKnown
);
   initial begin
      if (CNT_W < 4) begin
         $error("grs_ref_edge: CNT_W too small");
      end
   end

   logic [SYNC_STAGES-1:0] sync_r;
   logic level_r;
   logic [CNT_W-1:0] dur_r;
   logic [CNT_W-1:0] highLen_r;
   logic [CNT_W-1:0] lowLen_r;
   logic seenHigh_r;
   logic seenLow_r;
   logic leadPulse_r;
   logic activeHigh_r;
   logic polKnown_r;

   // A change counts only once the second and third stages agree.
   wire agreed = sync_r[1] == sync_r[2];
   wire change = agreed && (sync_r[2] != level_r);
   wire durMax = &dur_r;
   // The active level is the shorter one: the pulse, not the gap.
   wire polNxt = highLen_r < lowLen_r;
   wire bothSeen = seenHigh_r && seenLow_r;
   wire enterActive = change && (sync_r[2] == activeHigh_r);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync_r <= '0;
         level_r <= 1'b0;
         dur_r <= '0;
         highLen_r <= '0;
         lowLen_r <= '0;
         seenHigh_r <= 1'b0;
         seenLow_r <= 1'b0;
         leadPulse_r <= 1'b0;
         activeHigh_r <= 1'b0;
         polKnown_r <= 1'b0;
      end else begin
         sync_r <= {sync_r[1:0], refIn};
         leadPulse_r <= genlockEn && polKnown_r && enterActive;
         if (change) begin
            level_r <= sync_r[2];
            dur_r <= '0;
            if (level_r) begin
               highLen_r <= dur_r;
               seenHigh_r <= 1'b1;
            end else begin
               lowLen_r <= dur_r;
               seenLow_r <= 1'b1;
            end
         end else if (!durMax) begin
            dur_r <= dur_r + 1'b1;
         end
         if (!genlockEn) begin
            polKnown_r <= 1'b0;
            seenHigh_r <= 1'b0;
            seenLow_r <= 1'b0;
         end else if (bothSeen) begin
            activeHigh_r <= polNxt;
            polKnown_r <= 1'b1;
         end
      end
   end

   assign leadPulse = leadPulse_r;
   assign activeHigh = activeHigh_r;
   assign polKnown = polKnown_r;
endmodule

//--- logic/grs_ref_front.sv
`timescale 1ns/10ps
module grs_ref_front
   import grs_pkg::*;
#(
   parameter int REF_LOSS_CYCLES = grs_pkg::REF_LOSS_CYC,
   parameter int DUR_W = grs_pkg::DUR_CNT_W
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic genlockEn,
   input wire logic blankRefMode,
   input wire logic hRefIn,
   input wire logic vRefIn,
   input wire logic field_ref_in,
   input wire logic ten_field_ident_in,
   input wire logic [grs_pkg::SEL_W-1:0] video_format_select,
   output logic hLead,
   output logic vLead,
   output logic hActiveHigh,
   output logic vActiveHigh,
   output logic polKnown,
   output logic firstField,
   output logic tenFieldIdent,
   output logic fieldRefSeen,
   output logic [grs_pkg::SEL_W-1:0] formatCode,
   output grs_pkg::grs_rate_t clockRate,
   output logic [grs_pkg::TSET_W-1:0] timingSet,
   output logic formatValid,
   output logic upperSelSet,
   output logic refLocked
);
   import grs_pkg::*;

   localparam int LOSS_W = $clog2(REF_LOSS_CYCLES + 1);
   localparam int NSYNC = SEL_W + 4;

   initial begin
      if (REF_LOSS_CYCLES < 2) begin
         $error("grs_ref_front: REF_LOSS_CYCLES below 2");
      end
      if (DUR_W < 4) begin
         $error("grs_ref_front: DUR_W too small");
      end
   end

   // Static and slow pins share one synchroniser bank.
   wire [NSYNC-1:0] pinIn = {video_format_select, blankRefMode,
      genlockEn, ten_field_ident_in, field_ref_in};
   wire [NSYNC-1:0] pinVal;

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         logic [SYNC_STAGES-1:0] stg_r;
         logic val_r;
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               stg_r <= '0;
               val_r <= 1'b0;
            end else begin
               stg_r <= {stg_r[1:0], pinIn[gi]};
               if (stg_r[1] == stg_r[2]) begin
                  val_r <= stg_r[2];
               end
            end
         end
         assign pinVal[gi] = val_r;
      end
   endgenerate

   wire fieldS = pinVal[0];
   wire tenS = pinVal[1];
   wire genS = pinVal[2];
   wire blankS = pinVal[3];
   wire [SEL_W-1:0] selS = pinVal[NSYNC-1:4];

   wire hLeadW;
   wire vLeadW;
   wire hActW;
   wire vActW;
   wire hKnownW;
   wire vKnownW;

   grs_ref_edge #(.CNT_W(DUR_W)) u_hEdge (
      .ref_clk(ref_clk),
      .rst(rst),
      .genlockEn(genS),
      .refIn(hRefIn),
      .leadPulse(hLeadW),
      .activeHigh(hActW),
      .polKnown(hKnownW)
   );

   grs_ref_edge #(.CNT_W(DUR_W)) u_vEdge (
      .ref_clk(ref_clk),
      .rst(rst),
      .genlockEn(genS),
      .refIn(vRefIn),
      .leadPulse(vLeadW),
      .activeHigh(vActW),
      .polKnown(vKnownW)
   );

   // Format decode: only the low four bits pick among the output formats.
   wire [LOW_SEL_W-1:0] lowSel = selS[LOW_SEL_W-1:0];
   wire upperW = |selS[SEL_W-1:LOW_SEL_W];
   wire validW = !upperW && (lowSel != 4'h0)
      && (lowSel <= 4'(NUM_OUT_STDS));
   wire grs_rate_t rateW = RATE_TAB[lowSel];
   wire [TSET_W-1:0] tsetW = TSET_TAB[lowSel];

   // Field sense flips for blanking-based sources so firstField is uniform.
   wire firstW = blankS ? !fieldS : fieldS;

   logic hLead_r;
   logic vLead_r;
   logic hActiveHigh_r;
   logic vActiveHigh_r;
   logic polKnown_r;
   logic firstField_r;
   logic tenFieldIdent_r;
   logic fieldRefSeen_r;
   logic fieldPrev_r;
   logic [SEL_W-1:0] formatCode_r;
   grs_rate_t clockRate_r;
   logic [TSET_W-1:0] timingSet_r;
   logic formatValid_r;
   logic upperSelSet_r;
   logic refLocked_r;
   grs_state_t state_r;
   grs_state_t state_nxt;
   logic [LOSS_W-1:0] lossCnt_r;

   wire lossHit = lossCnt_r == LOSS_W'(REF_LOSS_CYCLES - 1);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_NOREF: begin
            if (vLeadW) begin
               state_nxt = ST_SEEK;
            end
         end
         ST_SEEK: begin
            if (!genS || lossHit) begin
               state_nxt = ST_NOREF;
            end else if (vLeadW) begin
               state_nxt = ST_LOCKED;
            end
         end
         ST_LOCKED: begin
            if (!genS || lossHit) begin
               state_nxt = ST_NOREF;
            end
         end
         default: begin
            state_nxt = ST_NOREF;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_NOREF;
         lossCnt_r <= '0;
      end else begin
         state_r <= state_nxt;
         if (vLeadW || state_r == ST_NOREF) begin
            lossCnt_r <= '0;
         end else if (!lossHit) begin
            lossCnt_r <= lossCnt_r + 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         hLead_r <= 1'b0;
         vLead_r <= 1'b0;
         hActiveHigh_r <= 1'b0;
         vActiveHigh_r <= 1'b0;
         polKnown_r <= 1'b0;
         refLocked_r <= 1'b0;
      end else begin
         hLead_r <= hLeadW;
         vLead_r <= vLeadW;
         hActiveHigh_r <= hActW;
         vActiveHigh_r <= vActW;
         polKnown_r <= hKnownW && vKnownW;
         refLocked_r <= state_nxt == ST_LOCKED;
      end
   end

   // Field and ten-field ident are taken at the vertical leading edge.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         firstField_r <= 1'b0;
         tenFieldIdent_r <= 1'b0;
         fieldRefSeen_r <= 1'b0;
         fieldPrev_r <= 1'b0;
      end else begin
         fieldPrev_r <= fieldS;
         if (vLeadW) begin
            firstField_r <= firstW;
            tenFieldIdent_r <= tenS;
         end
         // Any field activity means the source carries a field signal.
         if (!genS) begin
            fieldRefSeen_r <= 1'b0;
         end else if (fieldS != fieldPrev_r) begin
            fieldRefSeen_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         formatCode_r <= FMT_RST;
         clockRate_r <= RATE_27M;
         timingSet_r <= TSET_RST;
         formatValid_r <= 1'b0;
         upperSelSet_r <= 1'b0;
      end else begin
         formatCode_r <= selS;
         clockRate_r <= rateW;
         timingSet_r <= tsetW;
         formatValid_r <= validW;
         upperSelSet_r <= upperW;
      end
   end

   assign hLead = hLead_r;
   assign vLead = vLead_r;
   assign hActiveHigh = hActiveHigh_r;
   assign vActiveHigh = vActiveHigh_r;
   assign polKnown = polKnown_r;
   assign firstField = firstField_r;
   assign tenFieldIdent = tenFieldIdent_r;
   assign fieldRefSeen = fieldRefSeen_r;
   assign formatCode = formatCode_r;
   assign clockRate = clockRate_r;
   assign timingSet = timingSet_r;
   assign formatValid = formatValid_r;
   assign upperSelSet = upperSelSet_r;
   assign refLocked = refLocked_r;
endmodule

//--- tb/grs_ref_front_chk.sv
`timescale 1ns/10ps
module grs_ref_front_chk
   import grs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic genlockEn,
   input wire logic hRefIn,
   input wire logic vRefIn,
   input wire logic hActiveHigh,
   input wire logic vActiveHigh,
   input wire logic [grs_pkg::SEL_W-1:0] video_format_select,
   input wire logic hLead,
   input wire logic vLead,
   input wire logic polKnown,
   input wire logic [grs_pkg::SEL_W-1:0] formatCode,
   input wire logic formatValid,
   input wire logic upperSelSet,
   input wire logic refLocked
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   wire logic [3:0] lowSel = formatCode[3:0];
   wire logic validNow = formatCode[5:4] == 2'h0 && lowSel >= 4'h1 &&
      lowSel <= 4'hA;
   a_vlead_needs_pol: assert property (vLead |-> polKnown)
      else $error("vertical lead before polarity known");
   a_vlead_at_edge: assert property (vLead |->
      $past(vRefIn, 5) == vActiveHigh && $past(vRefIn, 6) != vActiveHigh)
      else $error("vertical lead not at leading edge");
   a_hlead_at_edge: assert property (hLead |->
      $past(hRefIn, 5) == hActiveHigh && $past(hRefIn, 6) != hActiveHigh)
      else $error("horizontal lead not at leading edge");
   a_vlead_single: assert property (vLead |=> !vLead)
      else $error("vertical lead longer than one cycle");
   a_valid_decode: assert property ($stable(formatCode) [*3] |->
      formatValid == validNow)
      else $error("format valid flag wrong");
   a_upper_flag: assert property ($stable(formatCode) [*3] |->
      upperSelSet == (formatCode[5:4] != 2'h0))
      else $error("upper select flag wrong");
   a_sync_follow: assert property ($stable(video_format_select) [*7] |->
      formatCode == video_format_select)
      else $error("format code does not follow select");
   a_off_no_lead: assert property (!genlockEn [*8] |-> !vLead && !hLead)
      else $error("lead pulse outside genlock");
   a_off_no_lock: assert property (!genlockEn [*8] |->
      !polKnown && !refLocked)
      else $error("lock kept after genlock dropped");
   cover property (vLead && refLocked);
   cover property (hLead);
   cover property ($rose(formatValid));
endmodule

bind grs_ref_front grs_ref_front_chk u_chk (
   .ref_clk(ref_clk),
   .rst(rst),
   .genlockEn(genlockEn),
   .hRefIn(hRefIn),
   .vRefIn(vRefIn),
   .hActiveHigh(hActiveHigh),
   .vActiveHigh(vActiveHigh),
   .video_format_select(video_format_select),
   .hLead(hLead),
   .vLead(vLead),
   .polKnown(polKnown),
   .formatCode(formatCode),
   .formatValid(formatValid),
   .upperSelSet(upperSelSet),
   .refLocked(refLocked)
);

//--- tb/grs_ref_src.sv
`timescale 1ns/10ps
module grs_ref_src (
   input wire logic ref_clk,
   input wire logic activeHigh,
   input wire logic fieldOn,
   input wire logic tenOn,
   output logic hRefIn,
   output logic vRefIn,
   output logic field_ref_in,
   output logic ten_field_ident_in
);
   int hCnt = 0;
   int vCnt = 0;
   int fieldCnt = 0;
   logic oddField = 1'b0;
   always @(negedge ref_clk) begin
      hCnt <= (hCnt == 19) ? 0 : hCnt + 1;
      vCnt <= (vCnt == 119) ? 0 : vCnt + 1;
      if (vCnt == 60) begin
         oddField <= ~oddField;
         fieldCnt <= (fieldCnt == 9) ? 0 : fieldCnt + 1;
      end
   end
   // Pulses are the short level so the device can infer their polarity.
   assign hRefIn = ((hCnt < 3) == activeHigh);
   assign vRefIn = ((vCnt < 4) == activeHigh);
   // A source without field sync ties the field pin low.
   assign field_ref_in = fieldOn && oddField;
   // The ten-field ident marks one field in ten, or is held low.
   assign ten_field_ident_in = tenOn && (fieldCnt == 0);
endmodule

//--- tb/genlock_reference_input_select_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
   miscompares++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, b); \
   end end
module genlock_reference_input_select_tb;
   import grs_pkg::*;
   logic ref_clk, rst, genlockEn, blankRefMode, srcHigh, fieldOn, tenOn;
   logic hRefIn, vRefIn, field_ref_in, ten_field_ident_in;
   logic [5:0] video_format_select, lastCode, code;
   logic hLead, vLead, hActiveHigh, vActiveHigh, polKnown, firstField;
   logic tenFieldIdent, fieldRefSeen, formatValid, upperSelSet, refLocked;
   logic [5:0] formatCode;
   logic [3:0] timingSet;
   grs_rate_t clockRate;
   logic [7:0] seed = 8'h1A;
   logic [13:0] expQ[$];
   int miscompares = 0;
   int checks_done = 0;
   grs_ref_src SRC (.ref_clk(ref_clk), .activeHigh(srcHigh),
      .fieldOn(fieldOn), .tenOn(tenOn),
      .hRefIn(hRefIn), .vRefIn(vRefIn), .field_ref_in(field_ref_in),
      .ten_field_ident_in(ten_field_ident_in));
   grs_ref_front #(.REF_LOSS_CYCLES(200)) DUT (.ref_clk(ref_clk), .rst(rst),
      .genlockEn(genlockEn), .blankRefMode(blankRefMode), .hRefIn(hRefIn),
      .vRefIn(vRefIn), .field_ref_in(field_ref_in),
      .ten_field_ident_in(ten_field_ident_in),
      .video_format_select(video_format_select), .hLead(hLead),
      .vLead(vLead), .hActiveHigh(hActiveHigh), .vActiveHigh(vActiveHigh),
      .polKnown(polKnown), .firstField(firstField),
      .tenFieldIdent(tenFieldIdent), .fieldRefSeen(fieldRefSeen),
      .formatCode(formatCode), .clockRate(clockRate), .timingSet(timingSet),
      .formatValid(formatValid), .upperSelSet(upperSelSet),
      .refLocked(refLocked));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [13:0] expFmt(input logic [5:0] c);
      logic ok;
      ok = c[5:4] == 2'h0 && c[3:0] >= 4'h1 && c[3:0] <= 4'hA;
      return {c, ok, |c[5:4], ok ? {RATE_TAB[c[3:0]], TSET_TAB[c[3:0]]} :
         6'h00};
   endfunction
   task automatic print_verdict();
      if (miscompares == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic setSel(input logic [5:0] c);
      if (c !== video_format_select) begin
         @(negedge ref_clk) video_format_select = c;
         expQ.push_back(expFmt(c));
         repeat (8) @(negedge ref_clk);
      end
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // Outputs move in the same cycle as the code, so comparing two later sees them settled.
   always @(negedge ref_clk) begin
      if (formatCode !== lastCode) begin
         lastCode = formatCode;
         repeat (2) @(negedge ref_clk);
         if (expQ.size() == 0) begin
            `CHK(formatCode, 6'h3F)
         end else begin
            `CHK({formatCode, formatValid, upperSelSet, formatValid ?
               {clockRate, timingSet} : 6'h00}, expQ.pop_front())
         end
      end
      if (vLead === 1'b1 && refLocked === 1'b1) begin
         `CHK({firstField, tenFieldIdent},
            {field_ref_in ^ blankRefMode, ten_field_ident_in})
      end
   end
   initial begin
      rst = 1'b1;
      genlockEn = 1'b0;
      blankRefMode = 1'b0;
      srcHigh = 1'b1;
      fieldOn = 1'b1;
      tenOn = 1'b1;
      video_format_select = 6'h00;
      lastCode = 6'h00;
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk) rst = 1'b0;
      for (int i = 0; i < 80; i++) begin
         code = (i < 16) ? seed[5:0] : 6'(i - 16);
         seed = lfsr(seed);
         setSel(code);
      end
      for (int p = 0; p < 2; p++) begin
         @(negedge ref_clk) genlockEn = 1'b0;
         srcHigh = (p == 0);
         blankRefMode = p[0];
         fieldOn = (p == 0);
         tenOn = (p == 0);
         repeat (10) @(negedge ref_clk);
         genlockEn = 1'b1;
         for (int k = 0; k < 2000 && refLocked !== 1'b1; k++) begin
            @(negedge ref_clk);
         end
         if (refLocked !== 1'b1) begin
            miscompares++;
            print_verdict();
         end
         repeat (1300) @(negedge ref_clk);
         `CHK({vActiveHigh, hActiveHigh, polKnown}, {srcHigh, srcHigh, 1'b1})
         `CHK(fieldRefSeen, fieldOn)
      end
      genlockEn = 1'b0;
      repeat (10) @(negedge ref_clk);
      `CHK({refLocked, polKnown}, 2'h0)
      `CHK(expQ.size(), 0)
      print_verdict();
   end
endmodule
